// file: sac_control.sv
// Purpose: control and sequencing of an 8-bit sar converter
// Assumes: analog sample-hold, comparator and tap string outside
// Notes:   cpu port writes bytes or single bits
`timescale 1ns/1ps
`default_nettype none

module sac_control #(
    parameter int SYNC_STAGES = 3
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // cpu access
    input  wire logic [15:0] cpu_addr,
    input  wire logic        cpu_wr,
    input  wire logic        cpu_bit_wr,
    input  wire logic [2:0]  cpu_bit_sel,
    input  wire logic [7:0]  cpu_wdata,
    input  wire logic        cpu_rd,
    output logic [7:0]       cpu_rdata,
    // power state
    input  wire logic        standby,
    // analog front end
    input  wire logic        comp_above,
    output logic [2:0]       channel_sel,
    output logic             sample_on,
    output logic             hold_on,
    output logic [7:0]       tap_code,
    // results
    output logic [7:0]       conversion_result,
    output logic             conversion_done_irq,
    output logic             conversion_active
);

    typedef struct packed {
        sac_pkg::sac_state_e state;
        logic [7:0]          mode;
        logic [7:0]          chan;
        logic [7:0]          result;
        logic [7:0]          rdata;
        logic [7:0]          cnt;
        logic [1:0]          slot;
        logic                irq;
        logic                sync_1;
        logic                sync_2;
        logic                sync_3;
        logic                comp;
    } sac_ctl_s;

    sac_ctl_s st_reg;
    sac_ctl_s st_next;

    logic       mode_hit;
    logic       chan_hit;
    logic       wr_any;
    logic [7:0] mode_wr_val;
    logic [7:0] chan_wr_val;
    logic [7:0] bit_mask;
    logic [7:0] slot_len;
    logic       slot_end;
    logic       sar_load;
    logic       sar_decide;
    logic [7:0] sar_trial;
    logic [7:0] sar_decided;
    logic       sar_last;

    // address decode
    assign mode_hit = (cpu_addr == sac_pkg::MODE_ADDR);
    assign chan_hit = (cpu_addr == sac_pkg::CHAN_ADDR);
    assign wr_any   = (cpu_wr | cpu_bit_wr) & (mode_hit | chan_hit);

    // byte or single bit merge
    always_comb begin
        bit_mask    = 8'h01 << cpu_bit_sel;
        mode_wr_val = st_reg.mode;
        chan_wr_val = st_reg.chan;
        if (cpu_wr) begin
            mode_wr_val = cpu_wdata;
            chan_wr_val = cpu_wdata;
        end else if (cpu_bit_wr) begin
            mode_wr_val = cpu_wdata[0] ? (st_reg.mode | bit_mask) : (st_reg.mode & ~bit_mask);
            chan_wr_val = cpu_wdata[0] ? (st_reg.chan | bit_mask) : (st_reg.chan & ~bit_mask);
        end
        mode_wr_val = mode_wr_val & sac_pkg::MODE_MASK;
        chan_wr_val = chan_wr_val & sac_pkg::CHAN_MASK;
    end

    // slot length from conversion time field
    always_comb begin
        unique case (st_reg.mode[sac_pkg::TIME_MSB:sac_pkg::TIME_LSB])
            sac_pkg::TIME_144: slot_len = sac_pkg::SLOT_144;
            sac_pkg::TIME_120: slot_len = sac_pkg::SLOT_120;
            sac_pkg::TIME_96:  slot_len = sac_pkg::SLOT_96;
            sac_pkg::TIME_72:  slot_len = sac_pkg::SLOT_72;
            sac_pkg::TIME_60:  slot_len = sac_pkg::SLOT_60;
            sac_pkg::TIME_48:  slot_len = sac_pkg::SLOT_48;
            default:           slot_len = sac_pkg::SLOT_144;
        endcase
    end

    assign slot_end = (st_reg.cnt == slot_len - 8'h01);

    // sar search engine
    sac_sar_step u_sar (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .load      (sar_load),
        .decide    (sar_decide),
        .comp_keep (st_reg.comp),
        .trial     (sar_trial),
        .decided   (sar_decided),
        .last_bit  (sar_last)
    );

    always_comb begin
        st_next  = st_reg;
        sar_load   = 1'b0;
        sar_decide = 1'b0;
        st_next.irq = 1'b0;

        // comparator synchroniser and agreement filter
        st_next.sync_1 = comp_above;
        st_next.sync_2 = st_reg.sync_1;
        st_next.sync_3 = st_reg.sync_2;
        if (st_reg.sync_2 == st_reg.sync_3) begin
            st_next.comp = st_reg.sync_3;
        end

        // read returns value held before this edge
        if (cpu_rd) begin
            if (mode_hit) begin
                st_next.rdata = st_reg.mode;
            end else if (chan_hit) begin
                st_next.rdata = st_reg.chan;
            end else if (cpu_addr == sac_pkg::RESULT_ADDR) begin
                st_next.rdata = st_reg.result;
            end else begin
                st_next.rdata = 8'h00;
            end
        end

        // control writes
        if (cpu_wr | cpu_bit_wr) begin
            if (mode_hit) begin
                st_next.mode = mode_wr_val;
            end
            if (chan_hit) begin
                st_next.chan = chan_wr_val;
            end
        end

        if (standby) begin
            st_next.state = sac_pkg::SAC_IDLE;
            st_next.cnt   = 8'h00;
            st_next.slot  = 2'h0;
        end else if (wr_any) begin
            // write wins over a coinciding conversion end
            st_next.cnt  = 8'h00;
            st_next.slot = 2'h0;
            if (st_next.mode[sac_pkg::ENABLE_BIT]) begin
                st_next.state = sac_pkg::SAC_SAMPLE;
            end else begin
                st_next.state = sac_pkg::SAC_IDLE;
            end
        end else begin
            unique case (st_reg.state)
                sac_pkg::SAC_IDLE: begin
                    // only resumes after standby with enable left set
                    if (st_reg.mode[sac_pkg::ENABLE_BIT]) begin
                        st_next.state = sac_pkg::SAC_SAMPLE;
                        st_next.cnt   = 8'h00;
                        st_next.slot  = 2'h0;
                    end
                end
                sac_pkg::SAC_SAMPLE: begin
                    if (slot_end) begin
                        st_next.cnt = 8'h00;
                        if (st_reg.slot == 2'(sac_pkg::SAMPLE_SLOTS - 1)) begin
                            st_next.state = sac_pkg::SAC_CONVERT;
                            st_next.slot  = 2'h0;
                            sar_load      = 1'b1;
                        end else begin
                            st_next.slot = st_reg.slot + 2'h1;
                        end
                    end else begin
                        st_next.cnt = st_reg.cnt + 8'h01;
                    end
                end
                sac_pkg::SAC_CONVERT: begin
                    if (slot_end) begin
                        st_next.cnt = 8'h00;
                        sar_decide  = 1'b1;
                        if (sar_last) begin
                            st_next.result = sar_decided;
                            st_next.irq    = 1'b1;
                            st_next.state  = sac_pkg::SAC_SAMPLE;
                        end
                    end else begin
                        st_next.cnt = st_reg.cnt + 8'h01;
                    end
                end
                default: begin
                    st_next.state = sac_pkg::SAC_IDLE;
                end
            endcase
        end
    end

    // result cleared for determinism only
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st_reg       <= '0;
            st_reg.mode  <= sac_pkg::MODE_RESET;
            st_reg.chan  <= sac_pkg::CHAN_RESET;
            st_reg.state <= sac_pkg::SAC_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs
    assign cpu_rdata           = st_reg.rdata;
    assign channel_sel         = st_reg.chan[sac_pkg::CHAN_MSB:0];
    assign sample_on           = (st_reg.state == sac_pkg::SAC_SAMPLE);
    assign hold_on             = (st_reg.state == sac_pkg::SAC_CONVERT);
    assign tap_code            = sar_trial;
    assign conversion_result   = st_reg.result;
    assign conversion_done_irq = st_reg.irq;
    assign conversion_active   = (st_reg.state != sac_pkg::SAC_IDLE);

endmodule : sac_control

`default_nettype wire

// file: sac_pkg.sv
// Purpose: shared constants for the sar converter control block
// Assumes: 8-bit cpu data, 16-bit cpu addresses
// Notes:   cycle counts are main clock periods
`default_nettype none

package sac_pkg;

    // register addresses
    localparam logic [15:0] MODE_ADDR   = 16'hff80;
    localparam logic [15:0] CHAN_ADDR   = 16'hff84;
    localparam logic [15:0] RESULT_ADDR = 16'hff88;

    // reset values
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] CHAN_RESET = 8'h00;

    // mode register fields
    localparam int ENABLE_BIT = 7;
    localparam int TIME_MSB   = 5;
    localparam int TIME_LSB   = 3;
    localparam logic [7:0] MODE_MASK = 8'hb8;

    // channel register fields
    localparam int CHAN_MSB = 2;
    localparam logic [7:0] CHAN_MASK = 8'h07;
    localparam logic [2:0] CHAN_LAST = 3'h5;

    // conversion time codes
    localparam logic [2:0] TIME_144 = 3'h0;
    localparam logic [2:0] TIME_120 = 3'h1;
    localparam logic [2:0] TIME_96  = 3'h2;
    localparam logic [2:0] TIME_72  = 3'h4;
    localparam logic [2:0] TIME_60  = 3'h5;
    localparam logic [2:0] TIME_48  = 3'h6;

    // conversion time in clock periods per code
    localparam int CONV_144 = 144;
    localparam int CONV_120 = 120;
    localparam int CONV_96  = 96;
    localparam int CONV_72  = 72;
    localparam int CONV_60  = 60;
    localparam int CONV_48  = 48;

    // slot layout: sample slots then one slot per bit
    localparam int RES_BITS       = 8;
    localparam int SAMPLE_SLOTS   = 4;
    localparam int SLOTS_PER_CONV = SAMPLE_SLOTS + RES_BITS;

    // slot lengths derived from conversion times
    localparam logic [7:0] SLOT_144 = 8'(CONV_144 / SLOTS_PER_CONV);
    localparam logic [7:0] SLOT_120 = 8'(CONV_120 / SLOTS_PER_CONV);
    localparam logic [7:0] SLOT_96  = 8'(CONV_96 / SLOTS_PER_CONV);
    localparam logic [7:0] SLOT_72  = 8'(CONV_72 / SLOTS_PER_CONV);
    localparam logic [7:0] SLOT_60  = 8'(CONV_60 / SLOTS_PER_CONV);
    localparam logic [7:0] SLOT_48  = 8'(CONV_48 / SLOTS_PER_CONV);

    // approximation start value, half scale
    localparam logic [7:0] HALF_SCALE = 8'h80;

    // sequencer states
    typedef enum logic [1:0] {
        SAC_IDLE    = 2'b00,
        SAC_SAMPLE  = 2'b01,
        SAC_CONVERT = 2'b10
    } sac_state_e;

endpackage : sac_pkg

`default_nettype wire

// file: sac_sar_step.sv
// Purpose: successive approximation bit search
// Assumes: decide strobes arrive one per bit after load
// Notes:   trial value doubles as the tap code
`timescale 1ns/1ps
`default_nettype none

module sac_sar_step (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset,
    // control
    input  wire logic       load,
    input  wire logic       decide,
    input  wire logic       comp_keep,
    // results
    output logic [7:0]      trial,
    output logic [7:0]      decided,
    output logic            last_bit
);

    typedef struct packed {
        logic [7:0] approx;
        logic [7:0] probe;
    } sac_sar_s;

    sac_sar_s st_reg;
    sac_sar_s st_next;

    // current bit kept on comparator high, else cleared
    always_comb begin
        decided = comp_keep ? st_reg.approx : (st_reg.approx & ~st_reg.probe);
    end

    always_comb begin
        st_next = st_reg;
        if (load) begin
            st_next.approx = sac_pkg::HALF_SCALE;
            st_next.probe  = sac_pkg::HALF_SCALE;
        end else if (decide) begin
            st_next.probe  = {1'b0, st_reg.probe[7:1]};
            st_next.approx = decided | {1'b0, st_reg.probe[7:1]};
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign trial    = st_reg.approx;
    assign last_bit = st_reg.probe[0];

endmodule : sac_sar_step

`default_nettype wire

// file: sac_control_monitor.sv
// Purpose: port assertions for sac_control
// Assumes: one clock, async high reset
// Notes:   bound to every sac_control
`timescale 1ns/1ps
`default_nettype none

module sac_control_monitor #(
    parameter int SYNC_STAGES = 3
) (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        reset,
    // cpu access
    input wire logic [15:0] cpu_addr,
    input wire logic        cpu_wr,
    input wire logic        cpu_bit_wr,
    input wire logic [7:0]  cpu_wdata,
    input wire logic        cpu_rd,
    input wire logic [7:0]  cpu_rdata,
    // converter side
    input wire logic        standby,
    input wire logic [2:0]  channel_sel,
    input wire logic        sample_on,
    input wire logic        hold_on,
    input wire logic [7:0]  tap_code,
    input wire logic [7:0]  conversion_result,
    input wire logic        conversion_done_irq,
    input wire logic        conversion_active
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence s_mode_wr;
        cpu_wr && cpu_addr == sac_pkg::MODE_ADDR;
    endsequence
    sequence s_ctl_wr;
        (cpu_wr || cpu_bit_wr) && (cpu_addr == sac_pkg::MODE_ADDR || cpu_addr == sac_pkg::CHAN_ADDR);
    endsequence

    a_irq_one_pulse: assert property (conversion_done_irq |=> !conversion_done_irq)
        else $error("done pulse longer than one cycle");
    a_result_with_irq: assert property ($changed(conversion_result) |-> conversion_done_irq)
        else $error("result changed without done pulse");
    a_irq_after_hold: assert property (conversion_done_irq |-> $past(hold_on))
        else $error("done pulse not after decisions");
    a_halt_on_clear: assert property (s_mode_wr ##0 !cpu_wdata[7] |=> !conversion_active)
        else $error("conversion kept running after disable");
    a_restart_on_write: assert property (s_mode_wr ##0 (cpu_wdata[7] && !standby) |=> sample_on && !hold_on)
        else $error("write did not restart sampling");
    a_write_wins_end: assert property (s_ctl_wr |=> !conversion_done_irq)
        else $error("done pulse right after control write");
    a_sample_hold_excl: assert property (!(sample_on && hold_on))
        else $error("sample and hold together");
    a_active_decode: assert property (conversion_active == (sample_on || hold_on))
        else $error("active flag disagrees with phase");
    a_half_scale_start: assert property ($rose(hold_on) |-> tap_code == sac_pkg::HALF_SCALE)
        else $error("bit search not started at half scale");
    a_standby_stops: assert property (standby |=> !conversion_active && !conversion_done_irq)
        else $error("activity during standby");
    a_chan_readback: assert property (cpu_rd && cpu_addr == sac_pkg::CHAN_ADDR && !cpu_wr && !cpu_bit_wr
        |=> cpu_rdata == {5'h00, channel_sel})
        else $error("channel readback mismatch");
endmodule : sac_control_monitor

bind sac_control sac_control_monitor #(.SYNC_STAGES(SYNC_STAGES)) sac_control_monitor_i (
    .sys_clk(sys_clk), .reset(reset), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_bit_wr(cpu_bit_wr),
    .cpu_wdata(cpu_wdata), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .standby(standby),
    .channel_sel(channel_sel), .sample_on(sample_on), .hold_on(hold_on), .tap_code(tap_code),
    .conversion_result(conversion_result), .conversion_done_irq(conversion_done_irq),
    .conversion_active(conversion_active));

`default_nettype wire

// file: sac_analog_model.sv
// Purpose: behavioural sample-hold and comparator
// Assumes: levels are ideal 8-bit codes per channel
// Notes:   held level compared against tap code
`timescale 1ns/1ps
`default_nettype none

module sac_analog_model (
    // clock
    input  wire logic        sys_clk,
    // six input levels, channel 0 lowest
    input  wire logic [47:0] levels,
    // converter side
    input  wire logic [2:0]  channel_sel,
    input  wire logic        sample_on,
    input  wire logic [7:0]  tap_code,
    output logic             comp_above
);
    logic [7:0] held_reg;

    // track while sampling, frozen while holding
    always_ff @(posedge sys_clk) begin
        if (sample_on) begin
            held_reg <= (channel_sel > 3'h5) ? 8'h00 : levels[channel_sel*8 +: 8];
        end
    end

    // high when held level at or above tap
    assign comp_above = (held_reg >= tap_code);
endmodule : sac_analog_model

`default_nettype wire

// file: tb_top.sv
// Purpose: self-checking bench for sac_control
// Assumes: ideal analog model on the far side
// Notes:   table of time codes, then hand tests
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    typedef struct packed {
        logic [2:0] code;
        logic [2:0] chan;
        logic [7:0] cycles;
        logic [7:0] result;
    } sac_row_s;
    localparam logic [47:0] LEVELS = 48'ha3_55_7f_80_00_ff;
    localparam sac_row_s ROWS [6] = '{'{3'h0, 3'h0, 8'h90, 8'hff}, '{3'h1, 3'h5, 8'h78, 8'ha3},
        '{3'h2, 3'h3, 8'h60, 8'h7f}, '{3'h4, 3'h1, 8'h48, 8'h00}, '{3'h0, 3'h2, 8'h90, 8'h80},
        '{3'h2, 3'h4, 8'h60, 8'h55}};

    logic        sys_clk, reset, cpu_wr, cpu_bit_wr, cpu_rd, standby, comp_above;
    logic [15:0] cpu_addr;
    logic [2:0]  cpu_bit_sel, channel_sel;
    logic [7:0]  cpu_wdata, cpu_rdata, tap_code, conversion_result, rdata, cyc;
    logic        sample_on, hold_on, conversion_done_irq, conversion_active;
    int          n_errors = 0;
    int          num_checks = 0;

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    sac_control sac_control_i (.sys_clk(sys_clk), .reset(reset), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
        .cpu_bit_wr(cpu_bit_wr), .cpu_bit_sel(cpu_bit_sel), .cpu_wdata(cpu_wdata), .cpu_rd(cpu_rd),
        .cpu_rdata(cpu_rdata), .standby(standby), .comp_above(comp_above), .channel_sel(channel_sel),
        .sample_on(sample_on), .hold_on(hold_on), .tap_code(tap_code), .conversion_result(conversion_result),
        .conversion_done_irq(conversion_done_irq), .conversion_active(conversion_active));
    sac_analog_model sac_analog_model_i (.sys_clk(sys_clk), .levels(LEVELS), .channel_sel(channel_sel),
        .sample_on(sample_on), .tap_code(tap_code), .comp_above(comp_above));

    task automatic give_verdict();
        if (n_errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // kind 0 byte write, 1 bit write, 2 read
    task automatic bus(input logic [15:0] addr, input logic [7:0] data, input logic [2:0] sel,
                       input logic [1:0] kind);
        @(posedge sys_clk);
        #1;
        cpu_addr = addr;
        cpu_wdata = data;
        cpu_bit_sel = sel;
        cpu_wr = (kind == 2'h0);
        cpu_bit_wr = (kind == 2'h1);
        cpu_rd = (kind == 2'h2);
        @(posedge sys_clk);
        #1;
        cpu_wr = 1'b0;
        cpu_bit_wr = 1'b0;
        cpu_rd = 1'b0;
        rdata = cpu_rdata;
    endtask : bus

    task automatic wait_irq(output logic [7:0] cnt);
        cnt = 8'h00;
        do begin
            @(posedge sys_clk);
            #1;
            cnt++;
        end while (conversion_done_irq !== 1'b1 && cnt < 8'hfa);
        if (conversion_done_irq !== 1'b1) begin
            n_errors++;
            give_verdict();
        end
    endtask : wait_irq

    task automatic no_irq(input int n);
        logic [7:0] hits;
        hits = 8'h00;
        repeat (n) begin
            @(posedge sys_clk);
            #1;
            if (conversion_done_irq !== 1'b0) hits++;
        end
        check(hits, 8'h00);
        check({7'h00, conversion_active}, 8'h00);
    endtask : no_irq

    initial begin
        {reset, cpu_wr, cpu_bit_wr, cpu_rd, standby} = 5'b10000;
        {cpu_addr, cpu_wdata, cpu_bit_sel} = 27'h0;
        repeat (12) @(posedge sys_clk);
        #1 reset = 1'b0;
        foreach (ROWS[i]) begin
            bus(sac_pkg::CHAN_ADDR, {5'h00, ROWS[i].chan}, 3'h0, 2'h0);
            bus(sac_pkg::MODE_ADDR, {2'b10, ROWS[i].code, 3'h0}, 3'h0, 2'h0);
            wait_irq(cyc);
            wait_irq(cyc);
            check(cyc, ROWS[i].cycles);
            check(conversion_result, ROWS[i].result);
            bus(sac_pkg::RESULT_ADDR, 8'h00, 3'h0, 2'h2);
            check(rdata, ROWS[i].result);
        end
        reset = 1'b1;
        repeat (3) @(posedge sys_clk);
        #1 reset = 1'b0;
        bus(sac_pkg::MODE_ADDR, 8'h00, 3'h0, 2'h2);
        check(rdata, 8'h00);
        bus(sac_pkg::CHAN_ADDR, 8'h00, 3'h0, 2'h2);
        check(rdata, 8'h00);
        bus(16'hff90, 8'h00, 3'h0, 2'h2);
        check(rdata, 8'h00);
        bus(sac_pkg::MODE_ADDR, 8'h47, 3'h0, 2'h0);
        bus(sac_pkg::MODE_ADDR, 8'h00, 3'h0, 2'h2);
        check(rdata, 8'h00);
        bus(sac_pkg::CHAN_ADDR, 8'h01, 3'h1, 2'h1);
        bus(sac_pkg::CHAN_ADDR, 8'h00, 3'h0, 2'h2);
        check(rdata, 8'h02);
        check({7'h00, conversion_active}, 8'h00);
        bus(sac_pkg::MODE_ADDR, 8'h01, 3'h7, 2'h1);
        bus(sac_pkg::MODE_ADDR, 8'h00, 3'h0, 2'h2);
        check(rdata, 8'h80);
        check({7'h00, conversion_active}, 8'h01);
        wait_irq(cyc);
        wait_irq(cyc);
        check(conversion_result, 8'h80);
        repeat (60) @(posedge sys_clk);
        bus(sac_pkg::CHAN_ADDR, 8'h03, 3'h0, 2'h0);
        repeat (140) begin
            @(posedge sys_clk);
            #1 check({7'h00, conversion_done_irq}, 8'h00);
        end
        wait_irq(cyc);
        check(conversion_result, 8'h7f);
        bus(sac_pkg::CHAN_ADDR, 8'h00, 3'h0, 2'h0);
        repeat (142) @(posedge sys_clk);
        bus(sac_pkg::RESULT_ADDR, 8'h00, 3'h0, 2'h2);
        check(rdata, 8'h7f);
        check(conversion_result, 8'hff);
        check({7'h00, conversion_done_irq}, 8'h01);
        bus(sac_pkg::CHAN_ADDR, 8'h03, 3'h0, 2'h0);
        repeat (142) @(posedge sys_clk);
        bus(sac_pkg::CHAN_ADDR, 8'h03, 3'h0, 2'h0);
        check({7'h00, conversion_done_irq}, 8'h00);
        check(conversion_result, 8'hff);
        repeat (30) @(posedge sys_clk);
        bus(sac_pkg::MODE_ADDR, 8'h00, 3'h0, 2'h0);
        no_irq(300);
        bus(sac_pkg::MODE_ADDR, 8'h80, 3'h0, 2'h0);
        repeat (40) @(posedge sys_clk);
        #1 standby = 1'b1;
        no_irq(300);
        standby = 1'b0;
        wait_irq(cyc);
        wait_irq(cyc);
        check(cyc, 8'h90);
        give_verdict();
    end
endmodule : tb_top

`default_nettype wire
